// >>> common/sptrc_pkg.sv
// Constants and types shared by the serial port control block
package sptrc_pkg;

   // ---------------------------------------------------------------
   // Register offsets (plain register port, byte wide)
   // ---------------------------------------------------------------
   localparam logic [2:0] OFF_TRANSMIT_CONTROL_STATUS = 3'h0;
   localparam logic [2:0] OFF_RECEIVE_CONTROL_STATUS  = 3'h1;
   localparam logic [2:0] OFF_TX_DATA                 = 3'h2;
   localparam logic [2:0] OFF_RECEIVE_DATA_REGISTER   = 3'h3;
   localparam logic [2:0] OFF_BAUD_DIVISOR            = 3'h4;
   localparam logic [2:0] OFF_BUFFER_STATUS           = 3'h5;

   // ---------------------------------------------------------------
   // Transmit control/status field positions
   // ---------------------------------------------------------------
   localparam int BIT_CLOCK_SOURCE_SELECT   = 7;
   localparam int BIT_TX_NINE_BIT_SELECT    = 6;
   localparam int BIT_TRANSMIT_ENABLE_BIT   = 5;
   localparam int BIT_LINK_MODE_SELECT      = 4;
   localparam int BIT_BREAK_REQUEST         = 3;
   localparam int BIT_BAUD_SPEED_SELECT     = 2;
   localparam int BIT_SHIFT_REGISTER_EMPTY  = 1;
   localparam int BIT_NINTH_TRANSMIT_BIT    = 0;

   // ---------------------------------------------------------------
   // Receive control/status field positions
   // ---------------------------------------------------------------
   localparam int BIT_PORT_ENABLE               = 7;
   localparam int BIT_RX_NINE_BIT_SELECT        = 6;
   localparam int BIT_SINGLE_RECEIVE_ENABLE     = 5;
   localparam int BIT_CONTINUOUS_RECEIVE_ENABLE = 4;
   localparam int BIT_ADDRESS_DETECT_ENABLE     = 3;
   localparam int BIT_FRAMING_ERROR_FLAG        = 2;
   localparam int BIT_OVERRUN_ERROR_FLAG        = 1;
   localparam int BIT_NINTH_RECEIVE_BIT         = 0;

   // ---------------------------------------------------------------
   // Reset values and write masks
   // ---------------------------------------------------------------
   localparam logic [7:0] TCS_RESET      = 8'h00;
   localparam logic [7:0] TCS_WRITE_MASK = 8'hfd;
   localparam logic [4:0] RCS_CTL_RESET  = 5'h00;
   localparam logic [7:0] DIVISOR_RESET  = 8'h00;

   // ---------------------------------------------------------------
   // Timing counts
   // ---------------------------------------------------------------
   localparam logic [3:0] OVS_LAST       = 4'hf;  // 16 ticks per async bit
   localparam logic [3:0] OVS_HALF_LAST  = 4'h7;  // Middle of start bit
   localparam logic [3:0] BREAK_ZERO_BITS = 4'hc; // Zero bits after start
   localparam logic [3:0] BITS_EIGHT     = 4'h8;
   localparam logic [3:0] BITS_NINE      = 4'h9;
   localparam logic [1:0] LOW_SPEED_PRE_LAST = 2'h3; // Divide by 4 more

   // ---------------------------------------------------------------
   // State types
   // ---------------------------------------------------------------
   typedef enum logic [1:0] {TX_IDLE, TX_START, TX_DATA, TX_STOP} sptrc_tx_t;
   typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} sptrc_rx_t;

endpackage

// >>> sim/serial_port_tx_rx_control_bench.sv
// Self-checking bench for the serial port control block
`timescale 1ns/1ps
`default_nettype none
module serial_port_tx_rx_control_bench;
   import sptrc_pkg::*;
   logic       sys_clk = 1'b0, nrst = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, peer_line;
   logic [2:0] reg_addr = 3'h0;
   logic [7:0] reg_wdata = 8'h00, reg_rdata, rd_v;
   logic       tx_ck_out, tx_ck_oe, rx_dt_out, rx_dt_oe;
   logic [15:0] v;
   int         bad_count = 0, samples_checked = 0;
   wire logic  tx_ck_in = tx_ck_oe ? tx_ck_out : 1'b0; // Wire level of clock pin
   wire logic  rx_dt_in = rx_dt_oe ? rx_dt_out : peer_line;
   always #5 sys_clk = ~sys_clk;
   sptrc_top u_dut (.sys_clk, .nrst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .tx_ck_in,
      .tx_ck_out, .tx_ck_oe, .rx_dt_in, .rx_dt_out, .rx_dt_oe);
   sptrc_peer u_peer (.sys_clk, .line(peer_line));
   task automatic print_verdict();
      $display("compares %0d mismatches %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic chk(input string n, input logic [15:0] e, input logic [15:0] s);
      samples_checked++;
      if (s !== e) begin
         bad_count++;
         $display("CHECK FAILED %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      {reg_addr, reg_wdata, reg_wr} <= {a, d, 1'b1};
      @(posedge sys_clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rc(input logic [2:0] a, input logic [7:0] e, input string n);
      @(posedge sys_clk);
      {reg_addr, reg_rd} <= {a, 1'b1};
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      #1 rd_v = reg_rdata;
      chk(n, {8'h00, e}, {8'h00, rd_v});
   endtask
   // Sample the transmit line mid-bit, bounded wait for the start bit
   task automatic grab(input int n);
      int i;
      v = 16'h0000;
      for (i = 0; i < 500 && tx_ck_out !== 1'b0; i++) @(posedge sys_clk);
      if (i == 500) begin
         bad_count++;
         print_verdict();
      end
      repeat (8) @(posedge sys_clk);
      for (i = 0; i < n; i++) begin
         v[i] = tx_ck_out;
         repeat (16) @(posedge sys_clk);
      end
   endtask
   initial begin
      repeat (5) @(posedge sys_clk);
      nrst <= 1'b1;
      rc(3'h0, 8'h02, "tcs reset");
      rc(3'h1, 8'h00, "rcs reset");
      wr(3'h7, 8'hff);
      rc(3'h7, 8'h00, "unmapped");
      wr(3'h1, 8'h87);
      rc(3'h1, 8'h80, "rcs ro bits");
      wr(3'h0, 8'h67);
      wr(3'h2, 8'ha5);
      rc(3'h0, 8'h65, "shifter full");
      grab(11);
      chk("frame", {5'h00, 2'h3, 8'ha5, 1'b0}, v);
      rc(3'h0, 8'h67, "shifter empty");
      wr(3'h0, 8'h2c);
      wr(3'h2, 8'hff);
      grab(14);
      chk("break", 16'h2000, v);
      rc(3'h0, 8'h26, "break done");
      wr(3'h1, 8'hd8);
      u_peer.send(9'h033, 1'b1);
      u_peer.send(9'h15a, 1'b1);
      rc(3'h1, 8'hd9, "ninth rx");
      rc(3'h3, 8'h5a, "addr detect");
      wr(3'h1, 8'hd0);
      u_peer.send(9'h00f, 1'b0);
      rc(3'h1, 8'hd4, "framing");
      rc(3'h3, 8'h0f, "all accepted");
      u_peer.send(9'h101, 1'b1);
      u_peer.send(9'h102, 1'b1);
      rc(3'h1, 8'hd3, "overrun");
      wr(3'h1, 8'hc0);
      rc(3'h3, 8'h01, "first kept");
      rc(3'h1, 8'hc1, "overrun clr");
      // Sync master transmit, cut short by port disable mid-frame
      wr(3'h0, 8'hb0);
      wr(3'h2, 8'h3d);
      repeat (2) @(posedge sys_clk);
      #1 chk("sync tx oe", 16'h0001, {15'h0, rx_dt_oe});
      chk("sync d0", 16'h0001, {15'h0, rx_dt_out});
      wr(3'h1, 8'h00);
      #1 chk("off oe", 16'h0000, {15'h0, rx_dt_oe});
      wr(3'h1, 8'h90);
      wr(3'h0, 8'hb0);
      #1 chk("master oe", 16'h0001, {15'h0, tx_ck_oe});
      wr(3'h0, 8'h30);
      #1 chk("slave oe", 16'h0000, {15'h0, tx_ck_oe});
      print_verdict();
   end
endmodule
`default_nettype wire

// >>> sim/sptrc_chk_assertions.sv
// Port-level checker for the serial port control block
`timescale 1ns/1ps
`default_nettype none
module sptrc_chk
   import sptrc_pkg::*;
(
   input wire logic       sys_clk,
   input wire logic       nrst,
   input wire logic [2:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic       reg_wr,
   input wire logic       reg_rd,
   input wire logic [7:0] reg_rdata,
   input wire logic       tx_ck_oe,
   input wire logic       rx_dt_oe
);
   // Shadows of bits that hardware never self-clears
   logic pe_q, cr_q, sy_q, ms_q;
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!nrst);
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) {pe_q, cr_q, sy_q, ms_q} <= 4'h0;
      else if (reg_wr && reg_addr == OFF_RECEIVE_CONTROL_STATUS) {pe_q, cr_q} <= {reg_wdata[7], reg_wdata[4]};
      else if (reg_wr && reg_addr == OFF_TRANSMIT_CONTROL_STATUS) {ms_q, sy_q} <= {reg_wdata[7], reg_wdata[4]};
   end
   // Port held off for two cycles, with a register read in the second
   sequence s_off_rd(a);
      !pe_q ##1 (!pe_q && reg_rd && reg_addr == a);
   endsequence
   property p_off_pins; !pe_q |-> !tx_ck_oe && !rx_dt_oe; endproperty
   a_off_pins: assert property (p_off_pins) else $error("pins driven while off");
   property p_async_oe; pe_q && !sy_q |-> tx_ck_oe && !rx_dt_oe; endproperty
   a_async_oe: assert property (p_async_oe) else $error("async pin enables wrong");
   property p_mst_oe; pe_q && sy_q && ms_q |-> tx_ck_oe; endproperty
   a_mst_oe: assert property (p_mst_oe) else $error("master clock not driven");
   property p_slv_oe; pe_q && sy_q && !ms_q |-> !tx_ck_oe; endproperty
   a_slv_oe: assert property (p_slv_oe) else $error("slave drives clock");
   property p_rx_wins; pe_q && sy_q && cr_q |-> !rx_dt_oe; endproperty
   a_rx_wins: assert property (p_rx_wins) else $error("data driven in receive");
   property p_off_flags; s_off_rd(OFF_RECEIVE_CONTROL_STATUS) |=> reg_rdata[2:1] == 2'h0; endproperty
   a_off_flags: assert property (p_off_flags) else $error("error flags set while off");
   property p_off_empty; s_off_rd(OFF_TRANSMIT_CONTROL_STATUS) |=> reg_rdata[1]; endproperty
   a_off_empty: assert property (p_off_empty) else $error("shifter not empty while off");
   property p_rd_idle; !$past(reg_rd) |-> reg_rdata == 8'h00; endproperty
   a_rd_idle: assert property (p_rd_idle) else $error("read data outside read slot");
endmodule
bind sptrc_top sptrc_chk u_chk (.sys_clk, .nrst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
   .tx_ck_oe, .rx_dt_oe);
`default_nettype wire

// >>> sim/sptrc_peer.sv
// Remote async transceiver that drives the receive line
`timescale 1ns/1ps
`default_nettype none
module sptrc_peer (
   input  wire logic sys_clk,
   output logic      line
);
   initial line = 1'b1; // Idle line rests high
   // One frame, 16 clocks a bit; stop level selectable to force errors
   task automatic send(input logic [8:0] d, input logic stop);
      logic [10:0] f;
      f = {stop, d, 1'b0};
      for (int i = 0; i < 11; i++) begin
         @(posedge sys_clk);
         line <= f[i];
         repeat (15) @(posedge sys_clk);
      end
      @(posedge sys_clk);
      line <= 1'b1;
   endtask
endmodule
`default_nettype wire

// >>> src/sptrc_baud.sv
// Baud rate generator: one-cycle tick enable from the system clock
`timescale 1ns/1ps
`default_nettype none
module sptrc_baud
   import sptrc_pkg::*;
(
   input  wire logic       sys_clk,
   input  wire logic       nrst,
   input  wire logic       clr,
   input  wire logic [7:0] divisor,
   input  wire logic       high_speed,
   input  wire logic       sync_mode,
   output logic            tick
);

   // ---------------------------------------------------------------
   // Counters
   // ---------------------------------------------------------------
   logic [7:0] cnt_q;    // Main down counter
   logic [1:0] pre_q;    // Low speed prescaler
   logic       tick_q;   // Registered tick
   wire  [1:0] pre_last; // Prescaler wrap point for the current mode
   wire        cnt_zero; // Main counter at its end
   wire        pre_wrap; // Prescaler at its end

   // Low speed divides by four more; sync mode ignores speed select
   assign pre_last = (sync_mode | high_speed) ? 2'h0 : LOW_SPEED_PRE_LAST;
   assign cnt_zero = (cnt_q == 8'h00);
   // A greater-or-equal compare keeps a mode change from stalling the wrap
   assign pre_wrap = (pre_q >= pre_last);
   assign tick     = tick_q;

   // Count down, reload from divisor, step prescaler at each reload
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         cnt_q  <= 8'h00;
         pre_q  <= 2'h0;
         tick_q <= 1'b0;
      end else if (clr) begin
         cnt_q  <= 8'h00;
         pre_q  <= 2'h0;
         tick_q <= 1'b0;
      end else begin
         tick_q <= cnt_zero & pre_wrap;
         if (cnt_zero) begin
            cnt_q <= divisor;
            pre_q <= pre_wrap ? 2'h0 : pre_q + 2'h1;
         end else begin
            cnt_q <= cnt_q - 8'h01;
         end
      end
   end

endmodule
`default_nettype wire

// >>> src/sptrc_top.sv
// Serial transceiver control: registers, async and sync engines, pins
// ---------------------------------------------------------------
// How it works
// - Sync: clock source bit picks master or slave
// - Transmit nine-bit bit selects 9-bit characters
// - Transmit enable gates sending; in sync mode continuous receive, or single receive as master, overrides
// - Link mode bit selects sync or async
// - Async break request sends break, self-clears
// - Async speed bit picks high or low baud
// - Shift register empty status, reads one at reset
// - Ninth transmit bit sent as ninth data bit
// - Port enable owns pins; clear holds port reset
// - Receive nine-bit bit selects 9-bit reception
// - Sync master single receive, cleared when done
// - Async continuous receive enables the receiver
// - Sync continuous receive runs, beats single receive
// - Async 9-bit address detect keeps only ninth-bit-set characters
// - Without address detect all characters accepted
// - Overrun flag clears with continuous receive off or port off
// - Framing flag follows each newly buffered character
// - Ninth received bit shown in status
// ---------------------------------------------------------------
`timescale 1ns/1ps
`default_nettype none
module sptrc_top
   import sptrc_pkg::*;
(
   input  wire logic       sys_clk,
   input  wire logic       nrst,
   input  wire logic [2:0] reg_addr,
   input  wire logic [7:0] reg_wdata,
   input  wire logic       reg_wr,
   input  wire logic       reg_rd,
   output logic      [7:0] reg_rdata,
   input  wire logic       tx_ck_in,
   output logic            tx_ck_out,
   output logic            tx_ck_oe,
   input  wire logic       rx_dt_in,
   output logic            rx_dt_out,
   output logic            rx_dt_oe
);

   // ---------------------------------------------------------------
   // Software registers
   // ---------------------------------------------------------------
   logic [7:0] tcs_q;       // Transmit control bits
   logic [4:0] rcs_q;       // Receive control bits 7..3
   logic [7:0] div_q;       // Baud divisor
   logic [7:0] tx_buf_q;    // Transmit holding byte
   logic       tx_full_q;   // Holding byte waits for the shifter
   logic [7:0] rx_buf_q;    // Receive data register
   logic       rx_full_q;   // Receive data not yet read
   logic       ninth_receive_bit_q;      // Ninth bit of buffered character
   logic       framing_error_flag_q;      // Framing flag of buffered character
   logic       overrun_error_flag_q;      // Overrun flag
   logic [7:0] rdata_q;     // Read data, one cycle after strobe

   // Field views
   wire clk_src   = tcs_q[BIT_CLOCK_SOURCE_SELECT];
   wire tx9       = tcs_q[BIT_TX_NINE_BIT_SELECT];
   wire transmit_enable_bit      = tcs_q[BIT_TRANSMIT_ENABLE_BIT];
   wire sync_mode = tcs_q[BIT_LINK_MODE_SELECT];
   wire brk_req   = tcs_q[BIT_BREAK_REQUEST];
   wire hi_speed  = tcs_q[BIT_BAUD_SPEED_SELECT];
   wire ninth_transmit_bit      = tcs_q[BIT_NINTH_TRANSMIT_BIT];
   wire port_enable      = rcs_q[BIT_PORT_ENABLE - 3];
   wire rx9       = rcs_q[BIT_RX_NINE_BIT_SELECT - 3];
   wire single_receive_enable      = rcs_q[BIT_SINGLE_RECEIVE_ENABLE - 3];
   wire continuous_receive_enable      = rcs_q[BIT_CONTINUOUS_RECEIVE_ENABLE - 3];
   wire address_detect_enable     = rcs_q[BIT_ADDRESS_DETECT_ENABLE - 3];

   // ---------------------------------------------------------------
   // Decode
   // ---------------------------------------------------------------
   wire wr_tcs  = reg_wr & (reg_addr == OFF_TRANSMIT_CONTROL_STATUS);
   wire wr_rcs  = reg_wr & (reg_addr == OFF_RECEIVE_CONTROL_STATUS);
   wire wr_txd  = reg_wr & (reg_addr == OFF_TX_DATA);
   wire wr_div  = reg_wr & (reg_addr == OFF_BAUD_DIVISOR);
   wire rd_rxd  = reg_rd & (reg_addr == OFF_RECEIVE_DATA_REGISTER);
   wire port_off = ~port_enable;
   wire async_on = port_enable & ~sync_mode;
   wire sync_on  = port_enable & sync_mode;

   // ---------------------------------------------------------------
   // Pin synchronisers and baud tick
   // ---------------------------------------------------------------
   logic [1:0] pin_s1_q;  // First stage, read only by second stage
   logic [1:0] pin_s2_q;  // Synchronised {clock pin, data pin}
   logic [1:0] pin_d_q;   // Previous synchronised level
   logic       tick;      // Baud enable pulse
   wire        rxd     = pin_s2_q[0];
   wire        rxd_fall = pin_d_q[0] & ~pin_s2_q[0];
   wire        ck_fall  = pin_d_q[1] & ~pin_s2_q[1];

   // Two flops per pin before any logic looks at it
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         pin_s1_q <= 2'h3;
         pin_s2_q <= 2'h3;
         pin_d_q  <= 2'h3;
      end else begin
         pin_s1_q <= {tx_ck_in, rx_dt_in};
         pin_s2_q <= pin_s1_q;
         pin_d_q  <= pin_s2_q;
      end
   end

   sptrc_baud u_baud (
      .sys_clk    (sys_clk),
      .nrst       (nrst),
      .clr        (port_off),
      .divisor    (div_q),
      .high_speed (hi_speed),
      .sync_mode  (sync_mode),
      .tick       (tick)
   );

   // ---------------------------------------------------------------
   // Asynchronous transmitter
   // ---------------------------------------------------------------
   sptrc_tx_t  atx_st_q;   // Transmit state
   logic [3:0] atx_sub_q;  // Tick within bit
   logic [3:0] atx_cnt_q;  // Bits left
   logic [8:0] atx_sr_q;   // Transmit shift register
   logic       atx_line_q; // Line level
   logic       atx_brk_q;  // Current frame is a break
   wire        atx_end  = tick & (atx_sub_q == OVS_LAST);
   wire        atx_go   = async_on & transmit_enable_bit & tx_full_q & (atx_st_q == TX_IDLE);
   wire        brk_done = (atx_st_q == TX_STOP) & atx_end & atx_brk_q;

   // Start, data, stop; a break frame shifts only zeros
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         atx_st_q   <= TX_IDLE;
         atx_sub_q  <= 4'h0;
         atx_cnt_q  <= 4'h0;
         atx_sr_q   <= 9'h000;
         atx_line_q <= 1'b1;
         atx_brk_q  <= 1'b0;
      end else if (port_off) begin
         atx_st_q   <= TX_IDLE;
         atx_line_q <= 1'b1;
         atx_brk_q  <= 1'b0;
      end else begin
         if (tick) begin
            atx_sub_q <= atx_sub_q + 4'h1;
         end
         unique case (atx_st_q)
            TX_IDLE: begin
               if (atx_go) begin
                  atx_st_q   <= TX_START;
                  atx_sub_q  <= 4'h0;
                  atx_line_q <= 1'b0;
                  atx_brk_q  <= brk_req;
                  atx_sr_q   <= brk_req ? 9'h000 : {ninth_transmit_bit, tx_buf_q};
                  atx_cnt_q  <= brk_req ? BREAK_ZERO_BITS
                                        : (tx9 ? BITS_NINE : BITS_EIGHT);
               end
            end
            TX_START: begin
               if (atx_end) begin
                  atx_st_q   <= TX_DATA;
                  atx_line_q <= atx_sr_q[0];
                  atx_sr_q   <= {1'b0, atx_sr_q[8:1]};
               end
            end
            TX_DATA: begin
               if (atx_end) begin
                  atx_cnt_q <= atx_cnt_q - 4'h1;
                  if (atx_cnt_q == 4'h1) begin
                     atx_st_q   <= TX_STOP;
                     atx_line_q <= 1'b1;
                  end else begin
                     atx_line_q <= atx_sr_q[0];
                     atx_sr_q   <= {1'b0, atx_sr_q[8:1]};
                  end
               end
            end
            TX_STOP: begin
               if (atx_end) begin
                  atx_st_q  <= TX_IDLE;
                  atx_brk_q <= 1'b0;
               end
            end
         endcase
      end
   end

   // ---------------------------------------------------------------
   // Asynchronous receiver (16x oversampled)
   // ---------------------------------------------------------------
   sptrc_rx_t  arx_st_q;   // Receive state
   logic [3:0] arx_sub_q;  // Tick within bit
   logic [3:0] arx_cnt_q;  // Bits left
   logic [8:0] arx_sr_q;   // Receive shift register
   wire        arx_end  = tick & (arx_sub_q == OVS_LAST);
   wire        arx_done = (arx_st_q == RX_STOP) & arx_end;

   // Overrun blocks new starts until software clears the flag
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         arx_st_q  <= RX_IDLE;
         arx_sub_q <= 4'h0;
         arx_cnt_q <= 4'h0;
         arx_sr_q  <= 9'h000;
      end else if (port_off | ~async_on) begin
         arx_st_q <= RX_IDLE;
      end else begin
         if (tick) begin
            arx_sub_q <= arx_sub_q + 4'h1;
         end
         unique case (arx_st_q)
            RX_IDLE: begin
               if (continuous_receive_enable & ~overrun_error_flag_q & rxd_fall) begin
                  arx_st_q  <= RX_START;
                  arx_sub_q <= 4'h0;
               end
            end
            RX_START: begin
               // Recheck mid start bit to reject glitches
               if (tick & (arx_sub_q == OVS_HALF_LAST)) begin
                  arx_sub_q <= 4'h0;
                  arx_cnt_q <= rx9 ? BITS_NINE : BITS_EIGHT;
                  arx_st_q  <= rxd ? RX_IDLE : RX_DATA;
               end
            end
            RX_DATA: begin
               if (arx_end) begin
                  arx_sr_q  <= {rxd, arx_sr_q[8:1]};
                  arx_cnt_q <= arx_cnt_q - 4'h1;
                  if (arx_cnt_q == 4'h1) begin
                     arx_st_q <= RX_STOP;
                  end
               end
            end
            RX_STOP: begin
               if (arx_end) begin
                  arx_st_q <= RX_IDLE;
               end
            end
         endcase
      end
   end

   // ---------------------------------------------------------------
   // Synchronous engine (master or slave, one direction per frame)
   // ---------------------------------------------------------------
   logic       sy_run_q;   // Frame in progress
   logic       sy_recv_q;  // Frame direction is receive
   logic [3:0] sy_cnt_q;   // Bits left
   logic [8:0] sy_sr_q;    // Shift register
   logic       sy_ck_q;    // Master clock level
   logic       sy_dout_q;  // Data pin level
   wire sy_recv_req = continuous_receive_enable | (clk_src & single_receive_enable);
   wire sy_tx_ok    = transmit_enable_bit & tx_full_q & ~sy_recv_req;
   wire sy_start    = sync_on & ~sy_run_q & ((sy_recv_req & ~overrun_error_flag_q) | sy_tx_ok);
   wire sy_edge     = clk_src ? (tick & sy_ck_q) : ck_fall;
   wire sy_last     = sy_run_q & sy_edge & (sy_cnt_q == 4'h1);
   wire sy_rx_done  = sy_last & sy_recv_q;

   // Data changes after each falling clock and is sampled at it
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         sy_run_q  <= 1'b0;
         sy_recv_q <= 1'b0;
         sy_cnt_q  <= 4'h0;
         sy_sr_q   <= 9'h000;
         sy_ck_q   <= 1'b0;
         sy_dout_q <= 1'b0;
      end else if (port_off | ~sync_on) begin
         sy_run_q <= 1'b0;
         sy_ck_q  <= 1'b0;
      end else if (sy_start) begin
         sy_run_q  <= 1'b1;
         sy_recv_q <= sy_recv_req;
         sy_ck_q   <= 1'b0;
         sy_sr_q   <= {ninth_transmit_bit, tx_buf_q};
         sy_dout_q <= tx_buf_q[0];
         sy_cnt_q  <= (sy_recv_req ? rx9 : tx9) ? BITS_NINE : BITS_EIGHT;
      end else if (sy_run_q) begin
         if (clk_src & tick) begin
            sy_ck_q <= ~sy_ck_q;
         end
         if (sy_edge) begin
            sy_cnt_q <= sy_cnt_q - 4'h1;
            if (sy_recv_q) begin
               sy_sr_q <= {rxd, sy_sr_q[8:1]};
            end else begin
               sy_sr_q   <= {1'b0, sy_sr_q[8:1]};
               sy_dout_q <= sy_sr_q[1];
            end
            if (sy_cnt_q == 4'h1) begin
               sy_run_q <= 1'b0;
            end
         end
      end
   end

   // ---------------------------------------------------------------
   // Received character delivery
   // ---------------------------------------------------------------
   wire [8:0] rx_sr    = sync_mode ? sy_sr_q : arx_sr_q;
   wire [8:0] rx_word  = rx9 ? rx_sr : {1'b0, rx_sr[8:1]};
   wire       rx_done  = arx_done | sy_rx_done;
   wire       rx_bad   = arx_done & ~rxd;
   wire       rx_keep  = ~(~sync_mode & rx9 & address_detect_enable & ~rx_word[8]);
   wire       rx_load  = rx_done & rx_keep;
   wire       rx_free  = ~rx_full_q | rd_rxd;

   // Buffer, framing and overrun; a set beats a same-cycle read or receive-off clear, port off beats a set
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         rx_buf_q  <= 8'h00;
         rx_full_q <= 1'b0;
         ninth_receive_bit_q    <= 1'b0;
         framing_error_flag_q    <= 1'b0;
         overrun_error_flag_q    <= 1'b0;
      end else if (port_off) begin
         rx_full_q <= 1'b0;
         framing_error_flag_q    <= 1'b0;
         overrun_error_flag_q    <= 1'b0;
      end else begin
         if (rd_rxd) begin
            rx_full_q <= 1'b0;
         end
         if (!continuous_receive_enable) begin
            overrun_error_flag_q <= 1'b0;
         end
         if (rx_load & rx_free) begin
            rx_buf_q  <= rx_word[7:0];
            ninth_receive_bit_q    <= rx_word[8];
            framing_error_flag_q    <= rx_bad;
            rx_full_q <= 1'b1;
         end else if (rx_load) begin
            overrun_error_flag_q <= 1'b1;
         end
      end
   end

   // ---------------------------------------------------------------
   // Register writes and hardware self-clears
   // ---------------------------------------------------------------
   wire tx_take = atx_go | (sy_start & ~sy_recv_req);

   // Transmit control; a software write wins over the break self-clear
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         tcs_q <= TCS_RESET;
      end else if (wr_tcs) begin
         tcs_q <= reg_wdata & TCS_WRITE_MASK;
      end else if (brk_done) begin
         tcs_q[BIT_BREAK_REQUEST] <= 1'b0;
      end
   end

   // Receive control; single receive ends itself after one character
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         rcs_q <= RCS_CTL_RESET;
      end else if (wr_rcs) begin
         rcs_q <= reg_wdata[7:3];
      end else if (sy_rx_done & clk_src) begin
         rcs_q[BIT_SINGLE_RECEIVE_ENABLE - 3] <= 1'b0;
      end
   end

   // Divisor and transmit holding byte
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         div_q     <= DIVISOR_RESET;
         tx_buf_q  <= 8'h00;
         tx_full_q <= 1'b0;
      end else begin
         if (wr_div) begin
            div_q <= reg_wdata;
         end
         if (port_off) begin
            tx_full_q <= 1'b0;
         end else if (wr_txd) begin
            tx_buf_q  <= reg_wdata;
            tx_full_q <= 1'b1;
         end else if (tx_take) begin
            tx_full_q <= 1'b0;
         end
      end
   end

   // ---------------------------------------------------------------
   // Read path
   // ---------------------------------------------------------------
   wire shift_register_empty = (atx_st_q == TX_IDLE) & ~(sy_run_q & ~sy_recv_q);
   wire [7:0] tcs_view = {tcs_q[7:2], shift_register_empty, tcs_q[0]};
   wire [7:0] rcs_view = {rcs_q, framing_error_flag_q, overrun_error_flag_q, ninth_receive_bit_q};
   wire [7:0] rd_mux =
      (reg_addr == OFF_TRANSMIT_CONTROL_STATUS) ? tcs_view :
      (reg_addr == OFF_RECEIVE_CONTROL_STATUS)  ? rcs_view :
      (reg_addr == OFF_RECEIVE_DATA_REGISTER)   ? rx_buf_q :
      (reg_addr == OFF_BAUD_DIVISOR)            ? div_q    :
      (reg_addr == OFF_BUFFER_STATUS)           ? {6'h00, rx_full_q, tx_full_q} :
                                                  8'h00;

   // Data only in the cycle after the read strobe
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         rdata_q <= 8'h00;
      end else begin
         rdata_q <= reg_rd ? rd_mux : 8'h00;
      end
   end

   // ---------------------------------------------------------------
   // Pins: port enable hands them to the serial port
   // ---------------------------------------------------------------
   assign reg_rdata = rdata_q;
   assign tx_ck_out = sync_mode ? sy_ck_q : atx_line_q;
   assign tx_ck_oe  = port_enable & (~sync_mode | clk_src);
   assign rx_dt_out = sy_dout_q;
   assign rx_dt_oe  = sync_on & sy_run_q & ~sy_recv_q;
   // Speed select only shapes the tick inside the divider

endmodule
`default_nettype wire
